// *** core/cfl_loader.sv ***
// loader top: word fetch sequence, port 0 control word, read port
`timescale 1ns/1ps
module cfl_loader (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// configuration memory word port
	output cfl_pkg::cfl_mem_req_t mem_req,
	input wire cfl_pkg::cfl_mem_rsp_t mem_rsp,
	// switch configuration read port
	input wire cfl_pkg::cfl_cfg_req_t cfg_req,
	output cfl_pkg::cfl_cfg_rsp_t cfg_rsp,
	// load status
	output logic load_done
);
	import cfl_pkg::*;

	cfl_top_t top_ff, nxt_top;
	cfl_p5_t p5_fld;
	logic [31:0] pbd_img [NUM_PORTS];
	logic [31:0] pbc_img [NUM_PORTS];
	logic [NUM_PORTS-1:0] ld_pb;
	logic word_take;
	logic ld_p5;
	logic ld_pm;
	logic [7:0] fetch_addr;
	logic [31:0] dsi_img, lpvc_img, lpn_img, tc_img;
	logic [31:0] slot_img, slck_img, pm_img;
	logic rd_hit;
	logic [31:0] rd_data;

	// word accepted only while waiting for it
	assign word_take = (top_ff.st == CFL_WAIT) && mem_rsp.vld;
	assign ld_p5 = word_take && (top_ff.idx == IDX_P5);
	assign ld_pm = word_take && (top_ff.idx == IDX_PM0);

	always_comb begin
		case (top_ff.idx)
			IDX_P5: fetch_addr = WORD_P5;
			IDX_PM0: fetch_addr = WORD_PM0;
			default: fetch_addr = WORD_PB0
				+ 8'(top_ff.idx - IDX_PB0) * WORD_PB_STEP;
		endcase
	end

	cfl_p5_word u_p5 (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ld(ld_p5),
		.word(mem_rsp.data),
		.fld(p5_fld)
	);

	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_pb
		assign ld_pb[i] = word_take && (top_ff.idx == IDX_PB0 + 3'(i));
		cfl_pb_port u_pb (
			.mclk(mclk),
			.sys_rst(sys_rst),
			.ld(ld_pb[i]),
			.word(mem_rsp.data),
			.pbd_reg(pbd_img[i]),
			.pbc_reg(pbc_img[i])
		);
	end

	// fetch sequence and read answer
	always_comb begin
		nxt_top = top_ff;
		nxt_top.mreq.req = 1'b0;
		nxt_top.rsp = '0;
		case (top_ff.st)
			CFL_ISSUE: begin
				nxt_top.mreq.req = 1'b1;
				nxt_top.mreq.addr = fetch_addr;
				nxt_top.st = CFL_WAIT;
			end
			CFL_WAIT: begin
				if (mem_rsp.vld) begin
					if (top_ff.idx == IDX_PM0) begin
						nxt_top.st = CFL_DONE;
						nxt_top.done = 1'b1;
					end else begin
						nxt_top.idx = top_ff.idx + 3'h1;
						nxt_top.st = CFL_ISSUE;
					end
				end
			end
			CFL_DONE: nxt_top.st = CFL_DONE;
			default: nxt_top.st = CFL_ISSUE;
		endcase
		if (ld_pm) begin
			nxt_top.pm.rxp = mem_rsp.data[RXP_SRC];
			nxt_top.pm.l0s = mem_rsp.data[L0S_SRC +: FLD2_W];
			nxt_top.pm.l1d = mem_rsp.data[L1D_SRC +: FLD2_W];
			nxt_top.pm.d3l = mem_rsp.data[D3L_SRC +: FLD2_W];
		end
		if (cfg_req.rd && top_ff.done) begin
			nxt_top.rsp.vld = 1'b1;
			nxt_top.rsp.err = !rd_hit;
			nxt_top.rsp.data = rd_hit ? rd_data : '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			top_ff <= '0;
			top_ff.st <= CFL_ISSUE;
		end else begin
			top_ff <= nxt_top;
		end
	end

	assign mem_req = top_ff.mreq;
	assign cfg_rsp = top_ff.rsp;
	assign load_done = top_ff.done;

	always_comb begin
		dsi_img = RST_DSI;
		dsi_img[DSI_DST] = p5_fld.dsi;
		lpvc_img = RST_LPVC;
		lpvc_img[LPVC_DST] = p5_fld.lpvc;
		lpn_img = RST_LPN;
		lpn_img[LPN_DST +: LPN_W] = p5_fld.lpn;
		tc_img = RST_TCMAP;
		tc_img[TC_DST +: TC_W] = p5_fld.tc;
		slot_img = RST_SLOT;
		slot_img[SLOT_DST] = p5_fld.slot;
		slck_img = RST_SLCK;
		slck_img[SLCK_DST] = p5_fld.slck;
		pm_img = RST_PMCP;
		pm_img[RXP_DST] = top_ff.pm.rxp;
		pm_img[L0S_DST +: FLD2_W] = top_ff.pm.l0s;
		pm_img[L1D_DST +: FLD2_W] = top_ff.pm.l1d;
		pm_img[D3L_DST +: FLD2_W] = top_ff.pm.d3l;
	end

	// register select by port and offset
	always_comb begin
		rd_hit = 1'b0;
		rd_data = '0;
		case (cfg_req.off)
			OFF_DSI: begin
				rd_hit = (cfg_req.port == PORT_LAST);
				rd_data = dsi_img;
			end
			OFF_LPVC: begin
				rd_hit = (cfg_req.port == PORT_LAST);
				rd_data = lpvc_img;
			end
			OFF_LPN: begin
				rd_hit = (cfg_req.port == PORT_LAST);
				rd_data = lpn_img;
			end
			OFF_TCMAP: begin
				rd_hit = (cfg_req.port == PORT_LAST);
				rd_data = tc_img;
			end
			OFF_SLOT: begin
				rd_hit = (cfg_req.port == PORT_LAST);
				rd_data = slot_img;
			end
			OFF_SLCK: begin
				rd_hit = (cfg_req.port == PORT_LAST);
				rd_data = slck_img;
			end
			OFF_PMCP: begin
				rd_hit = (cfg_req.port == PORT_FIRST);
				rd_data = pm_img;
			end
			OFF_PBD: begin
				rd_hit = (cfg_req.port <= PORT_LAST);
				if (rd_hit) begin
					rd_data = pbd_img[cfg_req.port];
				end
			end
			OFF_PBC: begin
				rd_hit = (cfg_req.port <= PORT_LAST);
				if (rd_hit) begin
					rd_data = pbc_img[cfg_req.port];
				end
			end
			default: rd_hit = 1'b0;
		endcase
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_read_early;
		cfg_req.rd && !load_done;
	endsequence
	sequence s_read_late;
		cfg_req.rd && load_done;
	endsequence
	sequence s_pb_issue(logic [2:0] n);
		mem_req.req && (top_ff.idx == n);
	endsequence

	property p_dsi;
		logic [15:0] w;
		(ld_p5, w = mem_rsp.data) |=> dsi_img[DSI_DST] == w[DSI_SRC];
	endproperty
	a_dsi_copy: assert property (p_dsi)
		else $error("init flag not loaded");

	property p_lpvc;
		logic [15:0] w;
		(ld_p5, w = mem_rsp.data) |=> lpvc_img[LPVC_DST] == w[LPVC_SRC];
	endproperty
	a_lpvc_copy: assert property (p_lpvc)
		else $error("low priority vc bit not loaded");

	property p_lpn;
		logic [15:0] w;
		(ld_p5, w = mem_rsp.data)
			|=> lpn_img[LPN_DST +: LPN_W] == w[LPN_SRC +: LPN_W];
	endproperty
	a_lpn_copy: assert property (p_lpn)
		else $error("logical port number not loaded");

	property p_tc;
		logic [15:0] w;
		(ld_p5, w = mem_rsp.data)
			|=> tc_img[TC_DST +: TC_W] == w[TC_SRC +: TC_W];
	endproperty
	a_tc_map: assert property (p_tc)
		else $error("class map not loaded");

	a_pb_addr: assert property (
		(s_pb_issue(IDX_PB0) |-> mem_req.addr == WORD_PB0)
		and (s_pb_issue(IDX_PM0 - 3'h1) |-> mem_req.addr == WORD_PB_LAST))
		else $error("budget word address wrong");

	property p_pb0;
		logic [15:0] w;
		(ld_pb[0], w = mem_rsp.data) |=>
			pbd_img[0][PBB_DST +: PBB_W] == w[PBB_SRC +: PBB_W]
			&& pbd_img[0][PBS_DST +: PBS_W] == w[PBS_SRC +: PBS_W];
	endproperty
	a_pb_base: assert property (p_pb0)
		else $error("base power or scale not loaded");

	a_pb_scale: assert property (
		!ld_pb[NUM_PORTS-1] |=> $stable(pbd_img[NUM_PORTS-1][PBS_DST +: PBS_W]))
		else $error("data scale changed without load");

	property p_pmst;
		logic [15:0] w;
		(ld_pb[NUM_PORTS-1], w = mem_rsp.data) |=>
			pbd_img[NUM_PORTS-1][PBM_DST +: PBM_W] == w[PBM_SRC +: PBM_W];
	endproperty
	a_pb_state: assert property (p_pmst)
		else $error("pm state not loaded");

	property p_sys;
		logic [15:0] w;
		(ld_pb[2], w = mem_rsp.data) |=> pbc_img[2][PBY_DST] == w[PBY_SRC];
	endproperty
	a_pb_sysalloc: assert property (p_sys)
		else $error("system allocated not loaded");

	property p_rxp;
		logic [15:0] w;
		(ld_pm, w = mem_rsp.data) |=> pm_img[RXP_DST] == w[RXP_SRC];
	endproperty
	a_pm_rxpol: assert property (p_rxp)
		else $error("rx polarity bit not loaded");

	property p_l0s;
		logic [15:0] w;
		(ld_pm, w = mem_rsp.data)
			|=> pm_img[L0S_DST +: FLD2_W] == w[L0S_SRC +: FLD2_W];
	endproperty
	a_pm_l0s: assert property (p_l0s)
		else $error("l0s field not loaded");

	property p_l1d;
		logic [15:0] w;
		(ld_pm, w = mem_rsp.data)
			|=> pm_img[L1D_DST +: FLD2_W] == w[L1D_SRC +: FLD2_W];
	endproperty
	a_pm_l1dly: assert property (p_l1d)
		else $error("l1 delay field not loaded");

	property p_d3l;
		logic [15:0] w;
		(ld_pm, w = mem_rsp.data) |=> load_done
			&& pm_img[D3L_DST +: FLD2_W] == w[D3L_SRC +: FLD2_W];
	endproperty
	a_pm_d3l1: assert property (p_d3l)
		else $error("d3 to l1 field not loaded");

	property p_slot;
		logic [15:0] w;
		(ld_p5, w = mem_rsp.data) |=> slot_img[SLOT_DST] == w[SLOT_SRC]
			&& slck_img[SLCK_DST] == w[SLCK_SRC];
	endproperty
	a_slot_copy: assert property (p_slot)
		else $error("slot flags not loaded");

	a_no_early: assert property (
		s_read_early |=> !cfg_rsp.vld)
		else $error("read answered before load");

	a_read_answer: assert property (
		s_read_late |=> cfg_rsp.vld && (!cfg_rsp.err || cfg_rsp.data == '0))
		else $error("read after load not answered");
endmodule // cfl_loader

// *** pkg/cfl_pkg.sv ***
// shared types and constants of the port configuration word loader
package cfl_pkg;
	// load word addresses and fetch order
	localparam logic [7:0] WORD_P5 = 8'h6a;
	localparam logic [7:0] WORD_PB0 = 8'h70;
	localparam logic [7:0] WORD_PB_STEP = 8'h02;
	localparam logic [7:0] WORD_PB_LAST = 8'h7a;
	localparam logic [7:0] WORD_PM0 = 8'h80;
	localparam int NUM_PORTS = 6;
	localparam logic [2:0] PORT_FIRST = 3'h0;
	localparam logic [2:0] PORT_LAST = 3'h5;
	localparam logic [2:0] IDX_P5 = 3'h0;
	localparam logic [2:0] IDX_PB0 = 3'h1;
	localparam logic [2:0] IDX_PM0 = 3'h7;
	// configuration offsets
	localparam logic [11:0] OFF_DSI = 12'h040;
	localparam logic [11:0] OFF_PMCP = 12'h074;
	localparam logic [11:0] OFF_SLOT = 12'h0c0;
	localparam logic [11:0] OFF_LPN = 12'h0cc;
	localparam logic [11:0] OFF_SLCK = 12'h0d0;
	localparam logic [11:0] OFF_LPVC = 12'h144;
	localparam logic [11:0] OFF_TCMAP = 12'h154;
	localparam logic [11:0] OFF_PBD = 12'h214;
	localparam logic [11:0] OFF_PBC = 12'h218;
	// field positions: word source bit, register target bit
	localparam int DSI_SRC = 2, DSI_DST = 21;
	localparam int LPVC_SRC = 3, LPVC_DST = 4;
	localparam int LPN_SRC = 4, LPN_DST = 24, LPN_W = 3;
	localparam int TC_SRC = 9, TC_DST = 1, TC_W = 7;
	localparam int SLOT_SRC = 0, SLOT_DST = 24;
	localparam int SLCK_SRC = 1, SLCK_DST = 28;
	localparam int PBB_SRC = 0, PBB_DST = 0, PBB_W = 8;
	localparam int PBS_SRC = 8, PBS_DST = 8, PBS_W = 2;
	localparam int PBM_SRC = 10, PBM_DST = 13, PBM_W = 2;
	localparam int PBY_SRC = 15, PBY_DST = 0;
	localparam int RXP_SRC = 6, RXP_DST = 14;
	localparam int L0S_SRC = 4, L0S_DST = 12;
	localparam int L1D_SRC = 2, L1D_DST = 10;
	localparam int D3L_SRC = 0, D3L_DST = 8;
	localparam int FLD2_W = 2;
	// register default values
	localparam logic [31:0] RST_DSI = 32'h0000_0000;
	localparam logic [31:0] RST_PMCP = 32'h0000_0000;
	localparam logic [31:0] RST_SLOT = 32'h0000_0000;
	localparam logic [31:0] RST_LPN = 32'h0000_0000;
	localparam logic [31:0] RST_SLCK = 32'h0000_0000;
	localparam logic [31:0] RST_LPVC = 32'h0000_0000;
	localparam logic [31:0] RST_TCMAP = 32'h0000_0000;
	localparam logic [31:0] RST_PBD = 32'h0000_0000;
	localparam logic [31:0] RST_PBC = 32'h0000_0000;

	typedef enum logic [1:0] {CFL_ISSUE, CFL_WAIT, CFL_DONE} cfl_st_t;
	typedef struct packed {logic req; logic [7:0] addr;} cfl_mem_req_t;
	typedef struct packed {logic vld; logic [15:0] data;} cfl_mem_rsp_t;
	typedef struct packed {
		logic rd; logic [2:0] port; logic [11:0] off;
	} cfl_cfg_req_t;
	typedef struct packed {
		logic vld; logic err; logic [31:0] data;
	} cfl_cfg_rsp_t;
	typedef struct packed {
		logic dsi; logic lpvc; logic [2:0] lpn; logic [6:0] tc;
		logic slot; logic slck;
	} cfl_p5_t;
	typedef struct packed {
		logic [7:0] base; logic [1:0] scale; logic [1:0] pmst; logic sys;
	} cfl_pb_t;
	typedef struct packed {
		logic rxp; logic [1:0] l0s; logic [1:0] l1d; logic [1:0] d3l;
	} cfl_pm_t;
	typedef struct packed {
		cfl_st_t st; logic [2:0] idx; cfl_mem_req_t mreq; cfl_pm_t pm;
		logic done; cfl_cfg_rsp_t rsp;
	} cfl_top_t;
endpackage

// *** core/cfl_pb_port.sv ***
// power budget register pair of one port
`timescale 1ns/1ps
module cfl_pb_port (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// word load
	input wire logic ld,
	input wire logic [15:0] word,
	// register images
	output logic [31:0] pbd_reg,
	output logic [31:0] pbc_reg
);
	import cfl_pkg::*;

	cfl_pb_t pb_ff, nxt_pb;

	always_comb begin
		nxt_pb = pb_ff;
		if (ld) begin
			nxt_pb.base = word[PBB_SRC +: PBB_W];
			nxt_pb.scale = word[PBS_SRC +: PBS_W];
			nxt_pb.pmst = word[PBM_SRC +: PBM_W];
			nxt_pb.sys = word[PBY_SRC];
		end
		pbd_reg = RST_PBD;
		pbd_reg[PBB_DST +: PBB_W] = pb_ff.base;
		pbd_reg[PBS_DST +: PBS_W] = pb_ff.scale;
		pbd_reg[PBM_DST +: PBM_W] = pb_ff.pmst;
		pbc_reg = RST_PBC;
		pbc_reg[PBY_DST] = pb_ff.sys;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pb_ff <= '0;
		end else begin
			pb_ff <= nxt_pb;
		end
	end
endmodule // cfl_pb_port

// *** core/cfl_p5_word.sv ***
// port 5 load word field holder
`timescale 1ns/1ps
module cfl_p5_word (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// word load
	input wire logic ld,
	input wire logic [15:0] word,
	// loaded fields
	output cfl_pkg::cfl_p5_t fld
);
	import cfl_pkg::*;

	cfl_p5_t p5_ff, nxt_p5;

	always_comb begin
		nxt_p5 = p5_ff;
		if (ld) begin
			nxt_p5.dsi = word[DSI_SRC];
			nxt_p5.lpvc = word[LPVC_SRC];
			nxt_p5.lpn = word[LPN_SRC +: LPN_W];
			nxt_p5.tc = word[TC_SRC +: TC_W];
			nxt_p5.slot = word[SLOT_SRC];
			nxt_p5.slck = word[SLCK_SRC];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			p5_ff <= '0;
		end else begin
			p5_ff <= nxt_p5;
		end
	end

	assign fld = p5_ff;
endmodule // cfl_p5_word

// *** dv/cfl_mem_model.sv ***
// configuration memory model answering word fetches after a set delay
`timescale 1ns/1ps
module cfl_mem_model (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// word fetch port
	input wire cfl_pkg::cfl_mem_req_t mem_req,
	output cfl_pkg::cfl_mem_rsp_t mem_rsp,
	// image, pacing and stray pulse set by the bench
	input wire logic [7:0][15:0] img,
	input wire logic [3:0] dly,
	input wire logic spur
);
	import cfl_pkg::*;
	logic busy;
	logic [3:0] cnt;
	logic [7:0] addr;
	// budget words from 70h, step two
	function automatic logic [2:0] widx(logic [7:0] a);
		if (a == WORD_P5) return IDX_P5;
		if (a == WORD_PM0) return IDX_PM0;
		return 3'((a - WORD_PB0) >> 1) + IDX_PB0;
	endfunction
	always_ff @(posedge mclk) begin
		mem_rsp.vld <= 1'b0;
		// released data line toggles every cycle
		mem_rsp.data <= ~mem_rsp.data;
		if (sys_rst) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			addr <= 8'h00;
			mem_rsp.data <= 16'h5a5a;
		end else if (spur) begin
			mem_rsp.vld <= 1'b1;
			mem_rsp.data <= 16'hffff;
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			mem_rsp.vld <= 1'b1;
			mem_rsp.data <= img[widx(addr)];
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end else if (mem_req.req && dly == 4'h0) begin
			mem_rsp.vld <= 1'b1;
			mem_rsp.data <= img[widx(mem_req.addr)];
		end else if (mem_req.req) begin
			busy <= 1'b1;
			cnt <= dly - 4'h1;
			addr <= mem_req.addr;
		end
	end
endmodule // cfl_mem_model

// *** dv/cfl_loader_tb.sv ***
// self-checking bench of the port configuration word loader
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
	bad_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end end
module cfl_loader_tb;
	import cfl_pkg::*;
	typedef struct packed {logic err; logic [31:0] data;} cfl_note_t;
	logic mclk;
	logic sys_rst;
	logic load_done;
	logic spur;
	logic [3:0] dly;
	logic [7:0][15:0] img;
	logic [31:0] seed;
	cfl_mem_req_t mem_req;
	cfl_mem_rsp_t mem_rsp;
	cfl_cfg_req_t cfg_req;
	cfl_cfg_rsp_t cfg_rsp;
	cfl_note_t notes[$];
	cfl_note_t n;
	int bad_count;
	int tests_run;
	int aidx;
	logic [11:0] offs [10] = '{OFF_DSI, OFF_LPVC, OFF_LPN, OFF_TCMAP,
		OFF_SLOT, OFF_SLCK, OFF_PMCP, OFF_PBD, OFF_PBC, 12'h000};

	cfl_loader u_dut (.mclk(mclk), .sys_rst(sys_rst), .mem_req(mem_req),
		.mem_rsp(mem_rsp), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
		.load_done(load_done));
	cfl_mem_model u_mem (.mclk(mclk), .sys_rst(sys_rst), .mem_req(mem_req),
		.mem_rsp(mem_rsp), .img(img), .dly(dly), .spur(spur));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_addr(int i);
		if (i == 0) return WORD_P5;
		if (i == 7) return WORD_PM0;
		return WORD_PB0 + WORD_PB_STEP * 8'(i - 1);
	endfunction
	function automatic cfl_note_t exp_reg(logic [2:0] p, logic [11:0] off);
		logic [15:0] w5;
		logic [15:0] wb;
		cfl_note_t e;
		w5 = img[0];
		wb = (p <= 3'h5) ? img[int'(p) + 1] : 16'h0000;
		e = '{1'b0, 32'h0000_0000};
		if (p == 3'h5 && off == OFF_DSI) e.data[21] = w5[2];
		else if (p == 3'h5 && off == OFF_LPVC) e.data[4] = w5[3];
		else if (p == 3'h5 && off == OFF_LPN) e.data[26:24] = w5[6:4];
		else if (p == 3'h5 && off == OFF_TCMAP) e.data[7:1] = w5[15:9];
		else if (p == 3'h5 && off == OFF_SLOT) e.data[24] = w5[0];
		else if (p == 3'h5 && off == OFF_SLCK) e.data[28] = w5[1];
		else if (p == 3'h0 && off == OFF_PMCP) e.data[14:8] = img[7][6:0];
		else if (p <= 3'h5 && off == OFF_PBD)
			e.data = {17'h0, wb[11:10], 3'h0, wb[9:0]};
		else if (p <= 3'h5 && off == OFF_PBC) e.data[0] = wb[15];
		else e.err = 1'b1;
		return e;
	endfunction
	task automatic rd(logic [2:0] p, logic [11:0] off);
		@(posedge mclk);
		cfg_req <= '{1'b1, p, off};
		notes.push_back(exp_reg(p, off));
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic round(int r);
		int k;
		@(posedge mclk);
		sys_rst <= 1'b1;
		for (k = 0; k < 8; k++) img[k] <= 16'(rnd());
		dly <= 4'(r * 3);
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		// restart in the middle of a load
		if (r == 1) begin
			repeat (9) @(posedge mclk);
			sys_rst <= 1'b1;
			repeat (2) @(posedge mclk);
			sys_rst <= 1'b0;
		end
		@(posedge mclk);
		cfg_req <= '{1'b1, 3'h5, OFF_DSI};
		`CHK(load_done, 1'b0)
		repeat (4) @(posedge mclk);
		cfg_req.rd <= 1'b0;
		k = 0;
		while (load_done !== 1'b1 && k < 2000) begin
			@(posedge mclk);
			k++;
		end
		if (load_done !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		for (int pass = 0; pass < 2; pass++) begin
			for (int p = 0; p < 8; p++) begin
				foreach (offs[i]) rd(3'(p), offs[i]);
			end
			@(posedge mclk);
			cfg_req.rd <= 1'b0;
			repeat (3) @(posedge mclk);
			`CHK(notes.size(), 0)
			// stray memory word after loading
			@(posedge mclk);
			spur <= 1'b1;
			@(posedge mclk);
			spur <= 1'b0;
		end
	endtask

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(negedge mclk) begin
		if (sys_rst) begin
			aidx = 0;
		end else if (mem_req.req === 1'b1) begin
			`CHK(mem_req.addr, exp_addr(aidx))
			aidx++;
		end
		if (cfg_rsp.vld === 1'b1) begin
			`CHK(notes.size() != 0, 1'b1)
			if (notes.size() != 0) begin
				n = notes.pop_front();
				`CHK(cfg_rsp.err, n.err)
				`CHK(cfg_rsp.data, n.data)
			end
		end
	end
	initial begin
		seed = 32'hd6e2347a;
		sys_rst = 1'b1;
		spur = 1'b0;
		dly = 4'h0;
		img = '0;
		cfg_req = '0;
		bad_count = 0;
		tests_run = 0;
		aidx = 0;
		for (int r = 0; r < 3; r++) round(r);
		give_verdict();
	end
endmodule // cfl_loader_tb
